// ---- hw/lmx_exec.sv ----
// Executes literal loads, accumulator stores, indirect stores, no-op and
// software reset of an 8-bit core; registers are visible over AXI4-Lite.
// Assumes instructions come from logic on clk, one per cycle at most.
//
// Added by the designer: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "lmx_consts.svh"

module lmx_exec (
    input wire logic clk,
    input wire logic rst_b,
    input wire lmx_pkg::lmx_instr_s instr,
    output lmx_pkg::lmx_wr_s data_wr,
    output logic [4:0] bank_select_latch,
    output logic [6:0] program_counter_high_latch,
    output logic [7:0] timer_option,
    output logic dev_reset,
    output logic instr_done,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import lmx_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // 16-bit arithmetic wraps 0000h <-> ffffh by itself
    function automatic lmx_ptr_t ptr_step(input lmx_ptr_t p, input logic dec);
        ptr_step = dec ? p - 16'h0001 : p + 16'h0001;
    endfunction

    function automatic logic [7:0] lane(input logic [7:0] old, input logic [7:0] nw,
                                        input logic en);
        lane = en ? nw : old;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        case (a)
            `LMX_REG_ACC, `LMX_REG_BANK, `LMX_REG_PAGE, `LMX_REG_OPTION,
            `LMX_REG_PTR0, `LMX_REG_PTR1, `LMX_REG_STATUS, `LMX_REG_POWER_CONTROL,
            `LMX_REG_CTRL: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] acc;
    lmx_ptr_t ptr0;
    lmx_ptr_t ptr1;
    logic [2:0] status_flags;
    logic software_reset_flag;
    logic [7:0] ctrl;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic go;
    logic [13:0] w;
    logic is_nop;
    logic is_rst;
    logic is_opt;
    logic is_bank;
    logic is_store;
    logic is_page;
    logic is_lit;
    logic is_si;
    logic is_sio;
    logic sel;
    lmx_ptr_t ptr_cur;
    lmx_ptr_t ea;
    lmx_ptr_t next_ptr;
    lmx_ptr_t direct_addr;
    logic sw_we;

    assign go = instr.valid && !ctrl[`LMX_CTRL_HALT];
    assign w = instr.word;
    assign is_nop = go && w == `LMX_OP_NOP;
    assign is_rst = go && w == `LMX_OP_RESET;
    assign is_opt = go && w == `LMX_OP_OPTION;
    assign is_bank = go && w[13:5] == `LMX_OP_BANK;
    assign is_store = go && w[13:7] == `LMX_OP_STORE;
    assign is_page = go && w[13:7] == `LMX_OP_PAGE;
    assign is_lit = go && w[13:8] == `LMX_OP_LIT;
    assign is_si = go && w[13:3] == `LMX_OP_SI_MODE;
    assign is_sio = go && w[13:7] == `LMX_OP_SI_OFS;
    assign sel = is_sio ? w[6] : w[2];
    assign ptr_cur = sel ? ptr1 : ptr0;

    // Effective address and pointer after the store
    always_comb begin
        ea = ptr_cur;
        next_ptr = ptr_cur;
        if (is_sio) begin
            ea = ptr_cur + {{10{w[5]}}, w[5:0]};
        end else begin
            case (w[1:0])
                `LMX_UPD_PRE_INC: begin
                    ea = ptr_step(ptr_cur, 1'b0);
                    next_ptr = ea;
                end
                `LMX_UPD_PRE_DEC: begin
                    ea = ptr_step(ptr_cur, 1'b1);
                    next_ptr = ea;
                end
                `LMX_UPD_POST_INC: next_ptr = ptr_step(ptr_cur, 1'b0);
                `LMX_UPD_POST_DEC: next_ptr = ptr_step(ptr_cur, 1'b1);
                default: next_ptr = ptr_cur;
            endcase
        end
    end

    // The window registers hold no data; they stand for the pointed location
    always_comb begin
        case (w[6:0])
            `LMX_WIN0: direct_addr = ptr0;
            `LMX_WIN1: direct_addr = ptr1;
            default: direct_addr = {4'h0, bank_select_latch, w[6:0]};
        endcase
    end

    // ------------------------------------------------------------
    // Execution
    // ------------------------------------------------------------
    // Software reset returns core state, except ctrl and software_reset_flag (cleared, not set), to reset values in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_b || is_rst) begin
            acc <= `LMX_RST_BYTE;
        end else if (is_lit) begin
            acc <= w[7:0];
        end else if (sw_we && wr_addr == `LMX_REG_ACC) begin
            acc <= lane(acc, wr_data[7:0], wr_strb[0]);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b || is_rst) begin
            bank_select_latch <= 5'h00;
        end else if (is_bank) begin
            bank_select_latch <= w[4:0];
        end else if (sw_we && wr_addr == `LMX_REG_BANK && wr_strb[0]) begin
            bank_select_latch <= wr_data[4:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b || is_rst) begin
            program_counter_high_latch <= 7'h00;
        end else if (is_page) begin
            program_counter_high_latch <= w[6:0];
        end else if (sw_we && wr_addr == `LMX_REG_PAGE && wr_strb[0]) begin
            program_counter_high_latch <= wr_data[6:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b || is_rst) begin
            timer_option <= `LMX_RST_OPTION;
        end else if (is_opt) begin
            timer_option <= acc;
        end else if (sw_we && wr_addr == `LMX_REG_OPTION) begin
            timer_option <= lane(timer_option, wr_data[7:0], wr_strb[0]);
        end
    end

    // An indirect-store pointer update drops any software write to ptr0 or ptr1 in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_b || is_rst) begin
            ptr0 <= `LMX_RST_PTR;
            ptr1 <= `LMX_RST_PTR;
        end else if (is_si) begin
            if (sel) begin
                ptr1 <= next_ptr;
            end else begin
                ptr0 <= next_ptr;
            end
        end else if (sw_we && wr_addr == `LMX_REG_PTR0) begin
            ptr0 <= {lane(ptr0[15:8], wr_data[15:8], wr_strb[1]),
                     lane(ptr0[7:0], wr_data[7:0], wr_strb[0])};
        end else if (sw_we && wr_addr == `LMX_REG_PTR1) begin
            ptr1 <= {lane(ptr1[15:8], wr_data[15:8], wr_strb[1]),
                     lane(ptr1[7:0], wr_data[7:0], wr_strb[0])};
        end
    end

    // Only software writes the flags; of the executed words only the reset instruction touches them, clearing them
    always_ff @(posedge clk) begin
        if (!rst_b || is_rst) begin
            status_flags <= 3'h0;
        end else if (sw_we && wr_addr == `LMX_REG_STATUS && wr_strb[0]) begin
            status_flags <= wr_data[2:0];
        end
    end

    // Power-on sets the flag; the reset instruction clears it and beats
    // a software write in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            software_reset_flag <= 1'b1;
        end else if (is_rst) begin
            software_reset_flag <= 1'b0;
        end else if (sw_we && wr_addr == `LMX_REG_POWER_CONTROL && wr_strb[0]) begin
            software_reset_flag <= wr_data[`LMX_POWER_SWRST_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl <= `LMX_RST_BYTE;
        end else if (sw_we && wr_addr == `LMX_REG_CTRL) begin
            ctrl <= lane(ctrl, wr_data[7:0], wr_strb[0]);
        end
    end

    // Data-space write port, one cycle after the instruction
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            data_wr <= '0;
        end else begin
            data_wr.en <= is_store || is_si || is_sio;
            data_wr.addr <= is_store ? direct_addr : ea;
            data_wr.data <= acc;
        end
    end

    // A no-op only reports completion, like every accepted word
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            instr_done <= 1'b0;
            dev_reset <= 1'b0;
        end else begin
            instr_done <= go;
            dev_reset <= is_rst;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    // Address and data are taken in either order; the write lands once
    // both are held, then the response waits for bready
    assign sw_we = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `LMX_RESP_OKAY;
            wr_addr <= 8'h00;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                wr_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end
            if (sw_we) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(wr_addr) ? `LMX_RESP_OKAY : `LMX_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    logic [31:0] rd_word;

    always_comb begin
        case (s_axi_araddr)
            `LMX_REG_ACC: rd_word = {24'h0, acc};
            `LMX_REG_BANK: rd_word = {27'h0, bank_select_latch};
            `LMX_REG_PAGE: rd_word = {25'h0, program_counter_high_latch};
            `LMX_REG_OPTION: rd_word = {24'h0, timer_option};
            `LMX_REG_PTR0: rd_word = {16'h0, ptr0};
            `LMX_REG_PTR1: rd_word = {16'h0, ptr1};
            `LMX_REG_STATUS: rd_word = {29'h0, status_flags};
            `LMX_REG_POWER_CONTROL: rd_word = {31'h0, software_reset_flag};
            `LMX_REG_CTRL: rd_word = {24'h0, ctrl};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `LMX_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= mapped(s_axi_araddr) ? `LMX_RESP_OKAY : `LMX_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule

// ---- pkg/lmx_consts.svh ----
// Constants of the literal, move and indirect-store execution block.
// Assumes the including file is compiled after lmx_pkg.
`ifndef LMX_CONSTS_SVH
`define LMX_CONSTS_SVH

// ----------------------------------------------------------------
// Instruction encodings (14-bit word)
// ----------------------------------------------------------------
`define LMX_OP_NOP 14'h0000
`define LMX_OP_RESET 14'h0001
`define LMX_OP_OPTION 14'h0062
`define LMX_OP_SI_MODE 11'h002
`define LMX_OP_SI_OFS 7'h7f
`define LMX_OP_BANK 9'h001
`define LMX_OP_STORE 7'h01
`define LMX_OP_PAGE 7'h63
`define LMX_OP_LIT 6'h30
`define LMX_UPD_PRE_INC 2'b00
`define LMX_UPD_PRE_DEC 2'b01
`define LMX_UPD_POST_INC 2'b10
`define LMX_UPD_POST_DEC 2'b11
`define LMX_WIN0 7'h00
`define LMX_WIN1 7'h01

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define LMX_REG_ACC 8'h00
`define LMX_REG_BANK 8'h04
`define LMX_REG_PAGE 8'h08
`define LMX_REG_OPTION 8'h0c
`define LMX_REG_PTR0 8'h10
`define LMX_REG_PTR1 8'h14
`define LMX_REG_STATUS 8'h18
`define LMX_REG_POWER_CONTROL 8'h1c
`define LMX_REG_CTRL 8'h20

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define LMX_CTRL_HALT 0
`define LMX_POWER_SWRST_BIT 0
`define LMX_RST_BYTE 8'h00
`define LMX_RST_OPTION 8'hff
`define LMX_RST_PTR 16'h0000
`define LMX_RESP_OKAY 2'b00
`define LMX_RESP_SLVERR 2'b10

`endif

// ---- pkg/lmx_pkg.sv ----
// Types shared by the execution block and its users.
// Assumes nothing of its surroundings.
package lmx_pkg;

    typedef logic [15:0] lmx_ptr_t;

    // One instruction offered by the fetch stage
    typedef struct packed {
        logic valid;
        logic [13:0] word;
    } lmx_instr_s;

    // One write into the data space
    typedef struct packed {
        logic en;
        lmx_ptr_t addr;
        logic [7:0] data;
    } lmx_wr_s;

endpackage

// ---- tb/lmx_exec_monitor.sv ----
// Port-level checker of the execution block.
// Assumes one clock domain; bound to every lmx_exec instance below.
`timescale 1ns/1ps
`include "lmx_consts.svh"
module lmx_exec_monitor (
    input wire logic clk,
    input wire logic rst_b,
    input wire lmx_pkg::lmx_instr_s instr,
    input wire lmx_pkg::lmx_wr_s data_wr,
    input wire logic [4:0] bank_select_latch,
    input wire logic [6:0] program_counter_high_latch,
    input wire logic [7:0] timer_option,
    input wire logic dev_reset,
    input wire logic instr_done,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import lmx_pkg::*;
    // ----
    // Properties
    // ----
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read data late");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_done_cause: assert property (instr_done |-> $past(instr.valid))
        else $error("completion without instruction");
    a_reset_cause: assert property (dev_reset |-> instr_done && $past(instr.word) == `LMX_OP_RESET)
        else $error("device reset without instruction");
    a_reset_clears: assert property (dev_reset |-> bank_select_latch == 5'h00 &&
        program_counter_high_latch == 7'h00 && timer_option == 8'hff)
        else $error("software reset left state");
    a_bank_load: assert property (instr_done && $past(instr.word[13:5]) == `LMX_OP_BANK
        |-> bank_select_latch == $past(instr.word[4:0])) else $error("bank literal lost");
    a_page_load: assert property (instr_done && $past(instr.word[13:7]) == `LMX_OP_PAGE
        |-> program_counter_high_latch == $past(instr.word[6:0])) else $error("page literal lost");
    a_store_direct: assert property (instr_done && $past(instr.word[13:7]) == `LMX_OP_STORE &&
        $past(instr.word[6:1]) != 6'h00 |-> data_wr.en &&
        data_wr.addr == {4'h0, $past(bank_select_latch), $past(instr.word[6:0])})
        else $error("direct store address wrong");
    a_write_source: assert property (data_wr.en |-> instr_done)
        else $error("data write without instruction");
    a_nop_quiet: assert property (instr_done && $past(instr.word) == `LMX_OP_NOP
        |-> !data_wr.en && $stable(bank_select_latch) && $stable(timer_option)
        && $stable(program_counter_high_latch)) else $error("no-op changed state");
endmodule
bind lmx_exec lmx_exec_monitor i_monitor (.clk(clk), .rst_b(rst_b), .instr(instr),
    .data_wr(data_wr), .bank_select_latch(bank_select_latch), .timer_option(timer_option),
    .program_counter_high_latch(program_counter_high_latch), .dev_reset(dev_reset),
    .instr_done(instr_done), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ---- tb/literal_move_indirect_exec_bench.sv ----
// Self-checking bench of the execution block, random cases with corners.
// Assumes the design and its checker are compiled before it.
`timescale 1ns/1ps
`include "lmx_consts.svh"
module literal_move_indirect_exec_bench;
    import lmx_pkg::*;
    logic clk = 0, rst_b = 0, go = 1, done, rst_seen;
    lmx_instr_s instr = '0;
    lmx_wr_s data_wr, wr;
    logic [4:0] bank;
    logic [6:0] page;
    logic [7:0] opt, awaddr = 0, araddr = 0;
    logic dev_reset, instr_done, awready, wready, bvalid, arready, rvalid;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0, rdata;
    logic [1:0] bresp, rresp;
    int errors = 0, comparisons = 0;
    logic [31:0] reset_vals [9] = '{0, 0, 0, 'hff, 0, 0, 0, 1, 0};
    always #12.5 clk = ~clk;
    lmx_exec i_dut (.clk(clk), .rst_b(rst_b), .instr(instr), .data_wr(data_wr),
        .bank_select_latch(bank), .program_counter_high_latch(page), .timer_option(opt),
        .dev_reset(dev_reset), .instr_done(instr_done), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    // ----
    // Shared tasks
    // ----
    task automatic stop_test();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bounded wait: a hung handshake ends the run as a mismatch
    task automatic limit(inout int n);
        n++;
        if (n > 50) begin
            errors++;
            stop_test();
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge clk);
            limit(n);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        r = bresp;
        bready <= 0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge clk);
            limit(n);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 0;
    endtask
    // Completion is registered on the taking edge and checked 1 ns after it
    task automatic exec(input logic [13:0] w);
        @(posedge clk);
        instr <= {1'b1, w};
        @(posedge clk);
        instr <= '0;
        #1;
        done = instr_done;
        rst_seen = dev_reset;
        wr = data_wr;
        chk(done, go);
    endtask
    function automatic logic [15:0] eff(input logic [15:0] p, input logic [1:0] m);
        return (m == 2'b00) ? p + 16'h1 : (m == 2'b01) ? p - 16'h1 : p;
    endfunction
    function automatic logic [15:0] upd(input logic [15:0] p, input logic [1:0] m);
        return m[0] ? p - 16'h1 : p + 16'h1;
    endfunction
    // ----
    // Main sequence
    // ----
    initial begin
        logic [1:0] r, m;
        logic [31:0] d;
        logic [7:0] k, acc, pa;
        logic [6:0] f;
        logic [5:0] o;
        logic [15:0] p;
        logic n;
        repeat (2) @(posedge clk);
        rst_b <= 1;
        void'($urandom(86300));
        foreach (reset_vals[i]) begin
            axi_rd(8'(4 * i), d, r);
            chk(d, reset_vals[i]);
            chk(r, `LMX_RESP_OKAY);
        end
        axi_rd(8'h24, d, r);
        chk(r, `LMX_RESP_SLVERR);
        chk(d, 32'h0);
        axi_wr(8'h24, 32'h5a, r);
        chk(r, `LMX_RESP_SLVERR);
        $display("test reset values done");
        axi_wr(`LMX_REG_STATUS, 32'h5, r);
        chk(r, `LMX_RESP_OKAY);
        for (int i = 0; i < 16; i++) begin
            k = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
            exec({`LMX_OP_BANK, 1'b0, k[3:0]});
            chk(bank, {1'b0, k[3:0]});
            exec({`LMX_OP_PAGE, k[6:0]});
            chk(page, k[6:0]);
            exec({`LMX_OP_LIT, k});
            axi_rd(`LMX_REG_ACC, d, r);
            chk(d, k);
        end
        acc = k;
        axi_rd(`LMX_REG_STATUS, d, r);
        chk(d, 32'h5);
        $display("test literals done");
        for (int i = 0; i < 10; i++) begin
            f = 7'($urandom_range(127, 2));
            exec({`LMX_OP_STORE, f});
            chk({wr.en, wr.addr, wr.data}, {1'b1, 4'h0, 1'b0, k[3:0], f, acc});
        end
        for (int i = 0; i < 2; i++) begin
            p = 16'($urandom);
            axi_wr(`LMX_REG_PTR0 + 8'(4 * i), {16'h0, p}, r);
            exec({`LMX_OP_STORE, 7'(i)});
            chk({wr.en, wr.addr, wr.data}, {1'b1, p, acc});
        end
        $display("test direct store done");
        for (int i = 0; i < 24; i++) begin
            n = i[0];
            m = i[2:1];
            o = (i == 16) ? 6'h20 : (i == 17) ? 6'h1f : 6'($urandom);
            p = (i < 8) ? (m[0] ? 16'h0000 : 16'hffff) : 16'($urandom);
            pa = `LMX_REG_PTR0 + 8'(4 * n);
            axi_wr(pa, {16'h0, p}, r);
            if (i < 16) begin
                exec({`LMX_OP_SI_MODE, n, m});
                chk({wr.en, wr.addr, wr.data}, {1'b1, eff(p, m), acc});
                p = upd(p, m);
            end else begin
                exec({`LMX_OP_SI_OFS, n, o});
                chk({wr.en, wr.addr}, {1'b1, p + {{10{o[5]}}, o}});
            end
            axi_rd(pa, d, r);
            chk(d, {16'h0, p});
        end
        axi_rd(`LMX_REG_STATUS, d, r);
        chk(d, 32'h5);
        $display("test indirect store done");
        acc = 8'($urandom);
        exec({`LMX_OP_LIT, acc});
        exec(`LMX_OP_OPTION);
        chk(opt, acc);
        exec(`LMX_OP_NOP);
        chk({wr.en, bank, page, opt}, {1'b0, 1'b0, k[3:0], k[6:0], acc});
        axi_wr(`LMX_REG_CTRL, 32'h1, r);
        go = 0;
        exec({`LMX_OP_LIT, ~acc});
        axi_wr(`LMX_REG_CTRL, 32'h0, r);
        go = 1;
        axi_rd(`LMX_REG_ACC, d, r);
        chk(d, acc);
        $display("test option, no-op and halt done");
        exec(`LMX_OP_RESET);
        chk({rst_seen, bank, page, opt}, {1'b1, 5'h0, 7'h0, 8'hff});
        axi_rd(`LMX_REG_POWER_CONTROL, d, r);
        chk(d, 32'h0);
        axi_rd(`LMX_REG_PTR1, d, r);
        chk(d, 32'h0);
        axi_rd(`LMX_REG_STATUS, d, r);
        chk(d, 32'h0);
        $display("test software reset done");
        exec({`LMX_OP_LIT, 8'h3c});
        @(posedge clk);
        rst_b <= 0;
        repeat (2) @(posedge clk);
        rst_b <= 1;
        axi_rd(`LMX_REG_POWER_CONTROL, d, r);
        chk(d, 32'h1);
        axi_rd(`LMX_REG_ACC, d, r);
        chk(d, 32'h0);
        $display("test hardware reset done");
        stop_test();
    end
endmodule
